// ### hdl/sbtc_capture.sv
// passive scsi bus trace capture: snapshot, trigger, circular store, logical read
// Operation
// - circular trace store, 32K events by default, 128K optional, wraps to start
// - each event is 72 bits: data, slow lines, fast lines, parity, stamp, expansion, internal
// - REQ, ACK and ATN each stored as four samples per event
// - separate parity error flags for low and high data byte
// - standard mode snaps on REQ for data-in, ACK for data-out, within 20 ns
// - information transfers recorded only on strobes; idle bus makes no events
// - any change of RST, ATN, SEL or BSY records a snapshot within 20 ns
// - run enters tracing mode in every trigger setup; tracing indicator shows it
// - without trigger, writing starts at first activity after run, ends on stop
// - at end of store writing continues at start, overwriting oldest
// - on stop the write address is kept so oldest event maps to zero
// - after wrapped free run the newest event reads at the top logical address
// - post-trigger stops at once, at bus free, or after a count of events
// - with store-full or external trigger, stop once last location is written
// - pre-trigger: bus free resets the write address until the trigger
// - after pre-trigger, no address reset; stop when store fills, even mid-command
// - stop command ends tracing at once in every mode
// - time stamp has 20 ns steps and runs over 85 s before wrapping
// - expansion bits stored with each event; bit 0 falling edge clocks recording
// - filter: skip data, one or four edges, phase changes, ext clock, id, selections only
// - trigger sources: message match, with id, selection, timeout, parity, store full
// - external trigger input triggers on its falling edge when enabled
// - external sync output pulses low when the trigger happens
// - time stamp is a four-byte counter stepped at 50 MHz
// - pause halts recording and marks the seam; run resumes
`timescale 1ns/1ps
`default_nettype none
module sbtc_capture #(
	parameter int ADDR_W         = sbtc_pkg::STD_ADDR_W,
	parameter int SEL_TMO_CYCLES = sbtc_pkg::SEL_TMO_CYC
) (
	// clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  arst_n,
	// monitored scsi bus, active low pins, inputs only
	input  wire logic [15:0]           scsi_data_n,
	input  wire logic [1:0]            scsi_dp_n,
	input  wire logic                  scsi_bsy_n,
	input  wire logic                  scsi_sel_n,
	input  wire logic                  scsi_rst_n,
	input  wire logic                  scsi_msg_n,
	input  wire logic                  scsi_cd_n,
	input  wire logic                  scsi_io_n,
	input  wire logic                  scsi_req_n,
	input  wire logic                  scsi_ack_n,
	input  wire logic                  scsi_atn_n,
	// auxiliary pins
	input  wire logic [2:0]            expansion_input_port,
	input  wire logic                  external_trigger_input,
	output var  logic                  external_sync_output_n,
	// commands, one-cycle pulses
	input  wire logic                  cmd_run,
	input  wire logic                  cmd_pause,
	input  wire logic                  cmd_stop,
	input  wire logic                  cmd_clear,
	// recording filter
	input  wire logic                  skip_data_en,
	input  wire logic                  skip_limit_sel,
	input  wire logic                  four_edge_en,
	input  wire logic                  phase_cap_en,
	input  wire logic                  ext_clk_en,
	input  wire logic                  id_filter_en,
	input  wire logic [15:0]           id_pattern,
	input  wire logic                  sel_only_en,
	// trigger setup
	input  wire sbtc_pkg::sbtc_trig_t  trig_mode,
	input  wire sbtc_pkg::sbtc_delay_t delay_mode,
	input  wire logic [15:0]           delay_count,
	input  wire logic                  trg_match_en,
	input  wire logic [2:0]            trg_match_phase,
	input  wire logic [7:0]            trg_match_value,
	input  wire logic                  trg_match_id_en,
	input  wire logic [15:0]           trg_match_id,
	input  wire logic                  trg_sel_en,
	input  wire logic                  trg_seltmo_en,
	input  wire logic                  trg_parity_en,
	input  wire logic                  trg_full_en,
	input  wire logic                  trg_ext_en,
	// logical read port
	input  wire logic [ADDR_W-1:0]     rd_addr,
	output var  logic [71:0]           rd_data,
	// status
	output var  logic                  tracing,
	output var  logic                  paused,
	output var  logic                  triggered,
	output var  logic                  wrapped,
	output var  logic                  evt_overrun,
	output var  logic                  clear_busy,
	output var  logic [ADDR_W-1:0]     wr_addr_phys,
	output var  logic [ADDR_W-1:0]     oldest_addr
);
	import sbtc_pkg::*;

	localparam int          DEPTH   = 1 << ADDR_W;
	localparam logic [25:0] TMO_LIM = 26'(SEL_TMO_CYCLES - 1);

	typedef struct packed {
		sbtc_pins_t        s1;
		sbtc_pins_t        s2;
		sbtc_pins_t        prv;
		logic [2:0]        req_sh;
		logic [2:0]        ack_sh;
		logic [2:0]        atn_sh;
		logic [2:0]        div;
		logic [31:0]       ts;
		sbtc_state_t       st;
		logic              tracing;
		logic              paused;
		logic              trg_fired;
		logic              bf_armed;
		logic [15:0]       dly_cnt;
		logic [5:0]        skip_cnt;
		logic              id_block;
		logic [15:0]       sel_ids;
		logic [25:0]       tmo_cnt;
		logic [5:0]        sync_cnt;
		logic              sync_n;
		logic              seam;
		logic              pend_v;
		sbtc_event_t       pend_d;
		logic              overrun;
		logic [ADDR_W-1:0] wr_addr;
		logic [ADDR_W-1:0] oldest;
		logic              wrapped;
		logic              clr_busy;
		logic [ADDR_W-1:0] clr_addr;
		logic [EVT_W-1:0]  rd_data;
	} sbtc_cap_st_t;

	sbtc_cap_st_t      r_reg;
	sbtc_cap_st_t      r_next;
	sbtc_pins_t        cur;
	sbtc_pins_t        prv;
	sbtc_event_t       evt;
	logic              busfree;
	logic              bf_enter;
	logic              info_ph;
	logic              data_ph;
	logic              qual;
	logic              any_strb;
	logic              ph_chg;
	logic              bs_chg;
	logic              ctl_chg;
	logic [5:0]        skip_lim;
	logic              skip_ok;
	logic [1:0]        perr;
	logic              ext_clk;
	logic              ext_trg;
	logic              ev;
	logic              tmo_hit;
	logic              match;
	logic              hit;
	logic              fire;
	logic              stop;
	logic              wr_last;
	logic              wrap_n;
	logic [ADDR_W-1:0] base;
	logic [ADDR_W-1:0] rd_phys;
	logic              mem_we;
	logic [ADDR_W-1:0] mem_addr;
	logic [EVT_W-1:0]  mem_wdata;

	logic [EVT_W-1:0]  trace_mem [DEPTH];

	// event path through the fifo; clearing stalls the drain
	sbtc_stream_if #(.W(EVT_W)) evt_in ();
	sbtc_stream_if #(.W(EVT_W)) evt_out ();

	sbtc_fifo #(
		.W     (EVT_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_sys (clk_sys),
		.arst_n  (arst_n),
		.in_s    (evt_in),
		.out_s   (evt_out)
	);

	assign evt_in.valid  = r_reg.pend_v;
	assign evt_in.data   = r_reg.pend_d;
	assign evt_out.ready = !r_reg.clr_busy;

	// observe only: pins flip to active high after the synchroniser
	assign cur = sbtc_pins_t'(r_reg.s2 ^ PIN_ACT_LOW);
	assign prv = sbtc_pins_t'(r_reg.prv ^ PIN_ACT_LOW);

	// bus phase decode
	assign busfree  = !cur.bsy && !cur.sel;
	assign bf_enter = busfree && (prv.bsy || prv.sel);
	assign info_ph  = cur.bsy && !cur.sel;
	assign data_ph  = info_ph && !cur.msg && !cur.cd;
	assign qual     = info_ph && (cur.io ? (cur.req && !prv.req) : (cur.ack && !prv.ack));
	assign any_strb = info_ph && ((cur.req ^ prv.req) || (cur.ack ^ prv.ack));
	assign ph_chg   = {cur.msg, cur.cd, cur.io} != {prv.msg, prv.cd, prv.io};
	assign bs_chg   = (cur.bsy ^ prv.bsy) || (cur.sel ^ prv.sel);
	assign ctl_chg  = bs_chg || (cur.rst ^ prv.rst) || (cur.atn ^ prv.atn);
	assign skip_lim = skip_limit_sel ? SKIP_LIM_B : SKIP_LIM_A;
	assign skip_ok  = !(skip_data_en && data_ph) || (r_reg.skip_cnt < skip_lim);
	assign perr     = {~^{cur.data[15:8], cur.dp[1]}, ~^{cur.data[7:0], cur.dp[0]}};
	assign ext_clk  = prv.exp[0] && !cur.exp[0];
	assign ext_trg  = prv.ext_trg && !cur.ext_trg;
	assign tmo_hit  = cur.sel && !cur.bsy && (r_reg.tmo_cnt == TMO_LIM);

	always_comb begin
		if (sel_only_en) begin
			ev = bs_chg;
		end else begin
			// only strobes and line changes make events
			ev = ((four_edge_en ? any_strb : qual) && skip_ok) || ctl_chg ||
			     (phase_cap_en && ph_chg) || (ext_clk_en && ext_clk);
		end
		ev = ev && !(r_reg.id_block && !busfree);
	end

	always_comb begin
		evt.internal = r_reg.seam;
		evt.exp      = cur.exp;
		evt.ts       = r_reg.ts;
		evt.perr     = perr;
		// three older samples plus the current one
		evt.atn      = {r_reg.atn_sh, cur.atn};
		evt.ack      = {r_reg.ack_sh, cur.ack};
		evt.req      = {r_reg.req_sh, cur.req};
		evt.slow     = {cur.bsy, cur.sel, cur.rst, cur.msg, cur.cd, cur.io};
		evt.data     = cur.data;
	end

	assign match = trg_match_en && qual && (cur.msg || cur.cd) &&
	               ({cur.msg, cur.cd, cur.io} == trg_match_phase) &&
	               (cur.data[7:0] == trg_match_value) &&
	               (!trg_match_id_en || (r_reg.sel_ids == trg_match_id));
	assign hit   = match || (trg_sel_en && cur.sel && !prv.sel) ||
	               (trg_seltmo_en && tmo_hit) || (trg_parity_en && qual && data_ph && |perr) ||
	               (trg_full_en && wr_last) || (trg_ext_en && ext_trg);
	assign fire  = (r_reg.st == ST_TRACE) && (trig_mode != TRG_NONE) && !r_reg.trg_fired && hit;

	assign rd_phys = rd_addr + r_reg.oldest;

	// next state
	always_comb begin
		r_next    = r_reg;
		mem_we    = 1'b0;
		mem_addr  = r_reg.wr_addr;
		mem_wdata = '0;
		stop      = 1'b0;
		wr_last   = 1'b0;
		base      = r_reg.wr_addr;
		wrap_n    = r_reg.wrapped;

		// two-stage synchroniser, then a history stage for edges
		r_next.s1  = {external_trigger_input, expansion_input_port, scsi_atn_n, scsi_ack_n,
		              scsi_req_n, scsi_io_n, scsi_cd_n, scsi_msg_n, scsi_rst_n, scsi_sel_n,
		              scsi_bsy_n, scsi_dp_n, scsi_data_n};
		r_next.s2  = r_reg.s1;
		r_next.prv = r_reg.s2;

		r_next.req_sh = {r_reg.req_sh[1:0], cur.req};
		r_next.ack_sh = {r_reg.ack_sh[1:0], cur.ack};
		r_next.atn_sh = {r_reg.atn_sh[1:0], cur.atn};

		// 50 MHz step from a divide-by-five enable
		if (r_reg.div == 3'(TS_DIV_CYC - 1)) begin
			r_next.div = 3'h0;
			// 32-bit stamp, 20 ns per step
			r_next.ts  = r_reg.ts + 32'h0000_0001;
		end else begin
			r_next.div = r_reg.div + 3'h1;
		end

		// skip-data counter restarts on each phase
		if (bf_enter || ph_chg) begin
			r_next.skip_cnt = 6'h00;
		end else if (skip_data_en && data_ph && qual && r_reg.skip_cnt < skip_lim) begin
			r_next.skip_cnt = r_reg.skip_cnt + 6'h01;
		end

		// selection ids, id filter verdict when select ends
		if (cur.sel && !cur.bsy) begin
			r_next.sel_ids = cur.data;
		end
		if (busfree) begin
			r_next.id_block = 1'b0;
		end else if (prv.sel && !cur.sel && cur.bsy) begin
			r_next.id_block = id_filter_en && (r_reg.sel_ids != id_pattern);
		end

		// selection timeout counter saturates at its limit
		if (cur.sel && !cur.bsy) begin
			if (r_reg.tmo_cnt != TMO_LIM) begin
				r_next.tmo_cnt = r_reg.tmo_cnt + 26'h000_0001;
			end
		end else begin
			r_next.tmo_cnt = '0;
		end

		// pending snapshot; a full fifo shows as overrun rather than silent loss
		if (evt_in.ready) begin
			r_next.pend_v = 1'b0;
		end
		if (r_reg.st == ST_TRACE && ev) begin
			if (!r_reg.pend_v || evt_in.ready) begin
				r_next.pend_v = 1'b1;
				r_next.pend_d = evt;
				r_next.seam   = 1'b0;
			end else begin
				r_next.overrun = 1'b1;
			end
		end

		// pre-trigger bus free restarts the address
		if (trig_mode == TRG_PRE && !r_reg.trg_fired && bf_enter && r_reg.st == ST_TRACE) begin
			base   = '0;
			wrap_n = 1'b0;
		end
		// drain into the store, wrapping to the start
		if (evt_out.valid && evt_out.ready && r_reg.st == ST_TRACE) begin
			mem_we    = 1'b1;
			mem_addr  = base;
			mem_wdata = evt_out.data;
			wr_last   = &base;
			base      = base + 1'b1;
			if (wr_last) begin
				wrap_n = 1'b1;
			end
		end
		r_next.wr_addr = base;
		r_next.wrapped = wrap_n;

		if (fire) begin
			r_next.trg_fired = 1'b1;
			r_next.sync_cnt  = 6'(SYNC_CYC);
			if (trig_mode == TRG_POST) begin
				unique case (delay_mode)
					DLY_NOW: begin
						stop = 1'b1;
					end
					DLY_BUSFREE: begin
						r_next.bf_armed = 1'b1;
					end
					DLY_COUNT: begin
						r_next.dly_cnt = delay_count;
						stop           = (delay_count == 16'h0000);
					end
					default: begin
						stop = 1'b1;
					end
				endcase
			end
		end else if (r_reg.trg_fired && trig_mode == TRG_POST && delay_mode == DLY_COUNT && mem_we) begin
			r_next.dly_cnt = r_reg.dly_cnt - 16'h0001;
			stop           = (r_reg.dly_cnt <= 16'h0001);
		end else if (r_reg.sync_cnt != 6'h00) begin
			r_next.sync_cnt = r_reg.sync_cnt - 6'h01;
		end
		r_next.sync_n = (r_next.sync_cnt == 6'h00);

		// delayed stop at the next bus free
		if (r_reg.bf_armed && bf_enter) begin
			stop = 1'b1;
		end
		// store-full or external trigger stops on the last location
		if (wr_last && trig_mode == TRG_POST && (trg_full_en || trg_ext_en)) begin
			stop = 1'b1;
		end
		// pre-trigger stops once the store fills after the trigger
		if (wr_last && trig_mode == TRG_PRE && r_reg.trg_fired) begin
			stop = 1'b1;
		end
		// stop command, no wait for bus free
		if (cmd_stop && r_reg.st != ST_IDLE) begin
			stop = 1'b1;
		end

		// keep the oldest surviving address on stop
		if (stop) begin
			r_next.st       = ST_IDLE;
			r_next.bf_armed = 1'b0;
			// wrapped run puts the newest event at the top logical address
			r_next.oldest   = wrap_n ? base : '0;
		end else begin
			unique case (r_reg.st)
				// run enters tracing in every trigger setup
				ST_IDLE: begin
					if (cmd_run && !r_reg.clr_busy) begin
						r_next.st        = ST_TRACE;
						r_next.wr_addr   = '0;
						r_next.wrapped   = 1'b0;
						r_next.oldest    = '0;
						r_next.trg_fired = 1'b0;
						r_next.bf_armed  = 1'b0;
						r_next.seam      = 1'b0;
						r_next.overrun   = 1'b0;
					end
				end
				// pause and resume with a seam mark
				ST_TRACE: begin
					if (cmd_pause) begin
						r_next.st = ST_PAUSE;
					end
				end
				ST_PAUSE: begin
					if (cmd_run) begin
						r_next.st   = ST_TRACE;
						r_next.seam = 1'b1;
					end
				end
			endcase
		end
		r_next.tracing = (r_next.st == ST_TRACE);
		r_next.paused  = (r_next.st == ST_PAUSE);

		// clear sweep, one word per cycle, only while idle
		if (r_reg.clr_busy) begin
			mem_we          = 1'b1;
			mem_addr        = r_reg.clr_addr;
			mem_wdata       = '0;
			r_next.clr_addr = r_reg.clr_addr + 1'b1;
			r_next.clr_busy = !(&r_reg.clr_addr);
		end else if (cmd_clear && r_reg.st == ST_IDLE) begin
			r_next.clr_busy = 1'b1;
			r_next.clr_addr = '0;
		end

		r_next.rd_data = trace_mem[rd_phys];
	end

	// store write port, no reset on the array
	always_ff @(posedge clk_sys) begin
		if (mem_we) begin
			trace_mem[mem_addr] <= mem_wdata;
		end
	end

	// state register; sync output idles high
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			r_reg        <= '0;
			r_reg.sync_n <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	// outputs straight from flip-flops
	assign external_sync_output_n = r_reg.sync_n;
	assign rd_data                = r_reg.rd_data;
	assign tracing                = r_reg.tracing;
	assign paused                 = r_reg.paused;
	assign triggered              = r_reg.trg_fired;
	assign wrapped                = r_reg.wrapped;
	assign evt_overrun            = r_reg.overrun;
	assign clear_busy             = r_reg.clr_busy;
	assign wr_addr_phys           = r_reg.wr_addr;
	assign oldest_addr            = r_reg.oldest;
endmodule : sbtc_capture
`default_nettype wire

// ### hdl/sbtc_pkg.sv
// shared constants and types of the scsi bus trace capture block
package sbtc_pkg;

	// clocking and derived cycle counts
	localparam int CLK_MHZ     = 250;
	localparam int TS_MHZ      = 50;
	localparam int TS_DIV_CYC  = CLK_MHZ / TS_MHZ;
	localparam int SEL_TMO_US  = 250;
	localparam int SEL_TMO_CYC = SEL_TMO_US * CLK_MHZ;
	localparam int SYNC_NS     = 200;
	localparam int SYNC_CYC    = (SYNC_NS * CLK_MHZ + 999) / 1000;

	// trace store geometry
	localparam int STD_ADDR_W  = 15;
	localparam int DEEP_ADDR_W = 17;
	localparam int EVT_W       = 72;
	localparam int FIFO_DEPTH  = 8;

	// skip-data transfer limits
	localparam logic [5:0] SKIP_LIM_A = 6'h08;
	localparam logic [5:0] SKIP_LIM_B = 6'h20;

	// bus pins that are active low inside the sampled pin word
	localparam logic [30:0] PIN_ACT_LOW = 31'h07FF_FFFF;

	// sampled pin word, lsb first: data, parity, bsy ... atn, expansion, ext trigger
	typedef struct packed {
		logic        ext_trg;
		logic [2:0]  exp;
		logic        atn;
		logic        ack;
		logic        req;
		logic        io;
		logic        cd;
		logic        msg;
		logic        rst;
		logic        sel;
		logic        bsy;
		logic [1:0]  dp;
		logic [15:0] data;
	} sbtc_pins_t;

	// one 72-bit trace event
	typedef struct packed {
		logic        internal;
		logic [2:0]  exp;
		logic [31:0] ts;
		logic [1:0]  perr;
		logic [3:0]  atn;
		logic [3:0]  ack;
		logic [3:0]  req;
		logic [5:0]  slow;
		logic [15:0] data;
	} sbtc_event_t;

	typedef enum logic [1:0] {ST_IDLE, ST_TRACE, ST_PAUSE} sbtc_state_t;
	typedef enum logic [1:0] {TRG_NONE, TRG_PRE, TRG_POST} sbtc_trig_t;
	typedef enum logic [1:0] {DLY_NOW, DLY_BUSFREE, DLY_COUNT} sbtc_delay_t;

endpackage : sbtc_pkg

// ### hdl/sbtc_stream_if.sv
// valid/ready event stream between capture logic and its fifo
`timescale 1ns/1ps
`default_nettype none
interface sbtc_stream_if #(
	parameter int W = sbtc_pkg::EVT_W
) ();
	logic         valid;
	logic         ready;
	logic [W-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : sbtc_stream_if
`default_nettype wire

// ### hdl/sbtc_fifo.sv
// small flip-flop fifo for trace events
`timescale 1ns/1ps
`default_nettype none
module sbtc_fifo #(
	parameter int W     = sbtc_pkg::EVT_W,
	parameter int DEPTH = sbtc_pkg::FIFO_DEPTH
) (
	// clock and reset
	input  wire logic   clk_sys,
	input  wire logic   arst_n,
	// filling side
	sbtc_stream_if.snk  in_s,
	// draining side
	sbtc_stream_if.src  out_s
);
	import sbtc_pkg::*;

	// pointers wrap by overflow, so depth must be a power of two
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wp;
		logic [AW-1:0]           rp;
		logic [AW:0]             cnt;
	} sbtc_fifo_st_t;

	sbtc_fifo_st_t r_reg;
	sbtc_fifo_st_t r_next;
	logic          push;
	logic          pop;

	// honest full and empty from the fill count
	assign in_s.ready  = (r_reg.cnt != (AW+1)'(DEPTH));
	assign out_s.valid = (r_reg.cnt != '0);
	assign out_s.data  = r_reg.mem[r_reg.rp];
	assign push        = in_s.valid && in_s.ready;
	assign pop         = out_s.valid && out_s.ready;

	// next state of storage and pointers
	always_comb begin
		r_next = r_reg;
		if (push) begin
			r_next.mem[r_reg.wp] = in_s.data;
			r_next.wp            = r_reg.wp + 1'b1;
		end
		if (pop) begin
			r_next.rp = r_reg.rp + 1'b1;
		end
		r_next.cnt = r_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	// state register
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end
endmodule : sbtc_fifo
`default_nettype wire

// ### verif/sbtc_capture_asserts.sv
// trace capture checker
`timescale 1ns/1ps
`default_nettype none
module sbtc_capture_asserts #(
	parameter int ADDR_W = sbtc_pkg::STD_ADDR_W
) (
	// clock and reset
	input wire logic                  clk_sys,
	input wire logic                  arst_n,
	// commands and setup
	input wire logic                  cmd_run,
	input wire logic                  cmd_pause,
	input wire logic                  cmd_stop,
	input wire sbtc_pkg::sbtc_trig_t  trig_mode,
	input wire sbtc_pkg::sbtc_delay_t delay_mode,
	// status
	input wire logic                  tracing,
	input wire logic                  paused,
	input wire logic                  triggered,
	input wire logic                  wrapped,
	input wire logic                  clear_busy,
	input wire logic                  external_sync_output_n,
	input wire logic [ADDR_W-1:0]     wr_addr_phys,
	input wire logic [ADDR_W-1:0]     oldest_addr
);
	import sbtc_pkg::*;

	// one clock domain
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	a_run_enter: assert property (
		cmd_run && !cmd_stop && !tracing && !paused && !clear_busy
		|=> tracing && !triggered && !wrapped && wr_addr_phys == '0) else $error("run not taken");
	a_stop_ends: assert property (
		cmd_stop && !cmd_run |=> !tracing && !paused) else $error("stop not taken");
	a_pause_holds: assert property (
		cmd_pause && tracing && !cmd_stop |=> paused && !tracing) else $error("pause not taken");
	a_sync_pulse: assert property (
		$fell(external_sync_output_n) |-> $rose(triggered) ##1 !external_sync_output_n [*7])
		else $error("sync pulse wrong");
	a_addr_step: assert property (
		tracing && $past(tracing) && $changed(wr_addr_phys)
		|-> wr_addr_phys == ADDR_W'($past(wr_addr_phys) + 1'b1) || wr_addr_phys == '0)
		else $error("write address jumped");
	a_oldest_kept: assert property (
		$fell(tracing) && !paused |-> oldest_addr == (wrapped ? wr_addr_phys : '0))
		else $error("oldest address wrong");
	a_none_quiet: assert property (
		trig_mode == TRG_NONE && !triggered |=> !triggered) else $error("trigger without mode");
	a_post_now: assert property (
		$rose(triggered) && trig_mode == TRG_POST && delay_mode == DLY_NOW |-> !tracing)
		else $error("no immediate stop");

	// scenarios
	c_trigger: cover property ($rose(triggered));
	c_wrap_stop: cover property ($fell(tracing) && wrapped);
	c_resume: cover property (paused && cmd_run);
endmodule : sbtc_capture_asserts

bind sbtc_capture sbtc_capture_asserts #(.ADDR_W(ADDR_W)) u_asserts (.*);
`default_nettype wire

// ### verif/sbtc_scsi_model.sv
// far-side bus devices
`timescale 1ns/1ps
`default_nettype none
module sbtc_scsi_model (
	// clock
	input  wire logic                 clk_sys,
	// bus pins 1 = asserted; aux pins at pin level, ext trigger idles high
	output var  sbtc_pkg::sbtc_pins_t pins
);
	import sbtc_pkg::*;

	// idle: all released
	initial pins = '{ext_trg: 1'b1, exp: 3'h5, default: 1'b0};

	// bsy and sel levels
	task automatic lines(input logic b, input logic s);
		@(posedge clk_sys);
		pins.bsy <= b;
		pins.sel <= s;
		repeat (8) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask : lines

	// one req/ack transfer, g cycles apart
	task automatic xfer(input logic i, input logic [15:0] d, input logic bad, input int g);
		@(posedge clk_sys);
		pins.io <= i;
		pins.data <= d;
		pins.dp <= {~^d[15:8] ^ bad, ~^d[7:0]};
		repeat (g) @(posedge clk_sys);
		pins.req <= 1'b1;
		repeat (g) @(posedge clk_sys);
		pins.ack <= 1'b1;
		repeat (g) @(posedge clk_sys);
		pins.req <= 1'b0;
		pins.data <= 16'h0000;
		pins.dp <= 2'h0;
		repeat (g) @(posedge clk_sys);
		pins.ack <= 1'b0;
		repeat (g) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask : xfer

	// external trigger pulse
	task automatic trg();
		@(posedge clk_sys);
		pins.ext_trg <= 1'b0;
		repeat (10) @(posedge clk_sys);
		pins.ext_trg <= 1'b1;
		@(negedge clk_sys);
	endtask : trg
endmodule : sbtc_scsi_model
`default_nettype wire

// ### verif/sbtc_capture_test.sv
// trace capture bench
`timescale 1ns/1ps
`default_nettype none
module sbtc_capture_test;
	import sbtc_pkg::*;
	localparam int AW = 6;
	localparam int DEPTH = 1 << AW;
	logic          clk_sys, arst_n, sync_n, trc, pau, trig, wrp;
	logic [3:0]    c;
	logic [13:0]   cfg;
	sbtc_trig_t    tm;
	sbtc_delay_t   dm;
	logic [AW-1:0] ra, wa, oa;
	logic [71:0]   rdat;
	sbtc_pins_t    p;
	int            failures = 0, checks = 0, cyc = 0;

	sbtc_scsi_model m (.clk_sys, .pins(p));
	sbtc_capture #(.ADDR_W(AW), .SEL_TMO_CYCLES(20)) DUT (.clk_sys, .arst_n,
		.scsi_data_n(~p.data), .scsi_dp_n(~p.dp), .scsi_bsy_n(~p.bsy), .scsi_sel_n(~p.sel),
		.scsi_rst_n(~p.rst), .scsi_msg_n(~p.msg), .scsi_cd_n(~p.cd), .scsi_io_n(~p.io),
		.scsi_req_n(~p.req), .scsi_ack_n(~p.ack), .scsi_atn_n(~p.atn),
		.expansion_input_port(p.exp), .external_trigger_input(p.ext_trg),
		.external_sync_output_n(sync_n), .cmd_run(c[0]), .cmd_pause(c[1]), .cmd_stop(c[2]),
		.cmd_clear(c[3]), .skip_data_en(cfg[0]), .skip_limit_sel(cfg[1]),
		.four_edge_en(cfg[2]), .phase_cap_en(cfg[3]), .ext_clk_en(cfg[4]),
		.id_filter_en(cfg[5]), .id_pattern(16'h0081), .sel_only_en(cfg[6]), .trig_mode(tm),
		.delay_mode(dm), .delay_count(16'h0002), .trg_match_en(cfg[7]),
		.trg_match_phase(3'h0), .trg_match_value(8'h00), .trg_match_id_en(cfg[8]),
		.trg_match_id({2'h0, cfg}), .trg_sel_en(cfg[9]), .trg_seltmo_en(cfg[10]),
		.trg_parity_en(cfg[11]), .trg_full_en(cfg[12]), .trg_ext_en(cfg[13]),
		.rd_addr(ra), .rd_data(rdat), .tracing(trc), .paused(pau), .triggered(trig),
		.wrapped(wrp), .evt_overrun(), .clear_busy(), .wr_addr_phys(wa), .oldest_addr(oa));

	task automatic report_and_stop();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [79:0] got, input logic [79:0] exp, input string s);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("FAIL at %0t: %s", $time, s);
		end
	endtask : chk

	task automatic nap(input int n);
		repeat (n) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask : nap

	// one-cycle command pulse
	task automatic cmd(input logic [3:0] v);
		@(posedge clk_sys);
		c <= v;
		@(posedge clk_sys);
		c <= 4'h0;
		nap(1);
	endtask : cmd

	// logical read
	task automatic rd(input int a, output logic [71:0] d);
		@(posedge clk_sys);
		ra <= AW'(a);
		nap(2);
		d = rdat;
	endtask : rd

	task automatic setup(input sbtc_trig_t t, input sbtc_delay_t dd);
		@(posedge clk_sys);
		tm <= t;
		dm <= dd;
	endtask : setup

	// clock
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	// hang guard
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			report_and_stop();
		end
	end

	initial begin
		logic [71:0] d;
		int          n;
		{arst_n, c, cfg, tm, dm, ra} = {1'b0, 4'h0, 14'h2000, TRG_NONE, DLY_NOW, 6'h00};
		repeat (16) @(posedge clk_sys);
		arst_n <= 1'b1;
		nap(2);
		cmd(4'h8);
		nap(DEPTH);
		chk({trc, pau, trig, wrp, sync_n, rdat}, 73'h1 << 72, "reset");
		// free run
		cmd(4'h1);
		m.lines(1'b1, 1'b0);
		m.xfer(1'b1, 16'h1234, 1'b0, 6);
		m.xfer(1'b0, 16'hA55A, 1'b1, 3);
		nap(30);
		chk(wa, 6'h03, "count");
		cmd(4'h4);
		rd(1, d);
		chk({d[70:68], d[35:34], d[26], d[22:0]}, {7'h51, 6'h21, 16'h1234}, "in");
		rd(2, d);
		chk({d[70:68], d[35:34], d[26], d[22:0]}, {7'h5B, 6'h20, 16'hA55A}, "out");
		$display("free run done");
		// wrap
		cmd(4'h1);
		for (int i = 0; i < DEPTH + 5; i++) m.xfer(1'b1, 16'(i), 1'b0, 2);
		nap(10);
		cmd(4'h4);
		chk({wrp, wa, oa}, {1'b1, 6'h05, 6'h05}, "wrap");
		rd(DEPTH - 1, d);
		chk(d[15:0], 16'(DEPTH + 4), "newest");
		rd(0, d);
		chk(d[15:0], 16'h0005, "oldest");
		$display("wrap done");
		// pause and resume
		cmd(4'h1);
		m.xfer(1'b1, 16'h0011, 1'b0, 2);
		cmd(4'h2);
		m.xfer(1'b1, 16'h0022, 1'b0, 2);
		nap(10);
		chk({pau, wa}, {1'b1, 6'h01}, "paused");
		cmd(4'h1);
		m.xfer(1'b1, 16'h0033, 1'b0, 2);
		nap(10);
		cmd(4'h4);
		rd(1, d);
		chk({d[71], d[15:0]}, {1'b1, 16'h0033}, "seam");
		$display("pause done");
		// post trigger
		for (int k = 0; k < 3; k++) begin
			setup(TRG_POST, sbtc_delay_t'(k));
			cmd(4'h1);
			m.trg();
			chk({trig, sync_n}, 2'h2, "trigger");
			repeat (3) m.xfer(1'b1, 16'h00C0, 1'b0, 2);
			nap(10);
			chk({trc, wa}, {k == 1, k == 1 ? 6'h03 : 6'(k)}, "post");
			m.lines(1'b0, 1'b0);
			chk(trc, 1'b0, "bus free");
			m.lines(1'b1, 1'b0);
		end
		$display("post trigger done");
		// pre trigger
		setup(TRG_PRE, DLY_NOW);
		cmd(4'h1);
		repeat (2) m.xfer(1'b1, 16'h0077, 1'b0, 2);
		m.lines(1'b0, 1'b0);
		nap(10);
		chk(wa <= 6'h01, 1'b1, "rewind");
		m.lines(1'b1, 1'b0);
		m.trg();
		for (n = 0; n < DEPTH + 8 && trc === 1'b1; n++) m.xfer(1'b1, 16'h0088, 1'b0, 2);
		chk({trc, wa, n <= DEPTH}, {1'b0, 6'h00, 1'b1}, "full stop");
		$display("pre trigger done");
		report_and_stop();
	end
endmodule : sbtc_capture_test
`default_nettype wire
